// >>> include/pbc_pkg.sv
// Constants and types for the PHY basic control and status register bank.
//
// Notes on behaviour
// (RULE1) Management reads and writes keep working while power-down is set.
// (RULE2) Power-down holds every MII output quiet, from its first cycle onward; the gate quiets them one cycle after the bit sets.
// (RULE3) Isolate makes the PHY ignore TXD, TX_EN and TX_ER completely.
// (RULE4) Isolate releases TX_CLK, RX_CLK, RX_DV, RX_ER, RXD, COL and CRS.
// (RULE5) Management transactions keep working while isolated.
// (RULE6) Restart bit starts negotiation, self-clears, reads one until negotiation begins; the code also clears it on a control write with bit 9 zero.
// (RULE7) Restart does nothing while negotiation is disabled; software keeps it clear.
// (RULE8) Writing zero to restart never disturbs a negotiation already running.
// (RULE9) Duplex bit forces full duplex when negotiation off, reports result when on.
// (RULE10) Collision test drives COL with every TX_EN assertion; resets to zero.
// (RULE11) Reserved control 6..0 and status 10..7 read zero; software writes zero.
// (RULE12) Capability bits fixed: T4 reads zero, 100/10 full/half read one.
// (RULE13) Preamble suppression bit reads zero: frames need a full preamble.
// (RULE14) Negotiation-complete reads one once negotiation finished; resets zero.
// (RULE15) Remote fault latches high after partner fault bit; clears on read or reset.
// (RULE16) Negotiation-ability bit is fixed at one.
// (RULE17) Link status reads one on valid link, latches low, resets zero.
// (RULE18) After a link failure link status stays zero until status is read.
// (RULE19) Bit 12 enables negotiation; then speed and duplex show the outcome.
// (RULE20) The management master sends a full preamble before every frame.
// (RULE21) Registers are 16 bits; only a completed status read clears latches; the code clears them when a status read's address phase ends.
package pbc_pkg;

    // ==========================================================
    // Register addresses and field positions
    localparam logic [4:0] REG_CONTROL = 5'h00;
    localparam logic [4:0] REG_STATUS = 5'h01;
    localparam int CTL_SPEED = 13;
    localparam int CTL_AN_ENABLE = 12;
    localparam int CTL_POWER_DOWN = 11;
    localparam int CTL_ISOLATE = 10;
    localparam int CTL_RESTART = 9;
    localparam int CTL_DUPLEX = 8;
    localparam int CTL_COL_TEST = 7;
    localparam int STS_AN_COMPLETE = 5;
    localparam int STS_REMOTE_FAULT = 4;
    localparam int STS_LINK = 2;

    // ==========================================================
    // Fixed status content: 100/10 full/half and negotiation ability
    localparam logic [15:0] STS_FIXED = 16'h7808;

    // ==========================================================
    // Values after reset
    localparam logic RST_SPEED = 1'b1;
    localparam logic RST_AN_ENABLE = 1'b1;
    localparam logic RST_POWER_DOWN = 1'b0;
    localparam logic RST_ISOLATE = 1'b0;
    localparam logic RST_RESTART = 1'b0;
    localparam logic RST_DUPLEX = 1'b1;
    localparam logic RST_COL_TEST = 1'b0;
    localparam logic RST_LINK = 1'b0;
    localparam logic RST_REMOTE_FAULT = 1'b0;

    // ==========================================================
    // Management frame format
    localparam logic [5:0] PREAMBLE_MIN = 6'h20;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [3:0] OPC_LAST = 4'h1;
    localparam logic [3:0] ADDR_LAST = 4'h9;
    localparam logic [3:0] DATA_LAST = 4'hF;

    typedef enum logic [2:0] {
        MG_PREAMBLE = 3'b000,
        MG_START = 3'b001,
        MG_OPCODE = 3'b010,
        MG_ADDRESS = 3'b011,
        MG_TURN = 3'b100,
        MG_DATA = 3'b101
    } pbc_mgmt_state_t;

endpackage : pbc_pkg

// >>> verilog/pbc_sync.sv
// Two-stage synchroniser for a bundle of pin inputs.
module pbc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } pbc_sync_state_t;

    pbc_sync_state_t s_d;
    pbc_sync_state_t s_q;

    // First stage feeds only the second
    always_comb begin
        s_d.stage1 = asyncIn;
        s_d.stage2 = s_q.stage1;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign syncOut = s_q.stage2;

endmodule : pbc_sync

// >>> verilog/pbc_mii_gate.sv
// Isolation, power-down and collision-test gating of the MAC-side MII.
module pbc_mii_gate (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic isolate,
    input wire logic powerDown,
    input wire logic colTest,
    input wire logic txEnSync,
    input wire logic txErSync,
    input wire logic [3:0] txdSync,
    input wire logic txClkCore,
    input wire logic rxClkCore,
    input wire logic rxDvCore,
    input wire logic rxErCore,
    input wire logic [3:0] rxdCore,
    input wire logic colCore,
    input wire logic crsCore,
    output logic txClkPin,
    output logic rxClkPin,
    output logic rxDvPin,
    output logic rxErPin,
    output logic [3:0] rxdPin,
    output logic colPin,
    output logic crsPin,
    output logic miiOe,
    output logic txEnCore,
    output logic txErCore,
    output logic [3:0] txdCore
);

    typedef struct packed {
        logic txClk;
        logic rxClk;
        logic rxDv;
        logic rxEr;
        logic [3:0] rxd;
        logic col;
        logic crs;
        logic oe;
        logic txEn;
        logic txEr;
        logic [3:0] txd;
    } pbc_gate_state_t;

    pbc_gate_state_t s_d;
    pbc_gate_state_t s_q;
    logic quiet;

    always_comb begin
        quiet = isolate | powerDown;
        s_d.oe = ~isolate; // RULE4
        // Quiet outputs are held low so nothing toggles
        s_d.txClk = quiet ? 1'b0 : txClkCore; // RULE2
        s_d.rxClk = quiet ? 1'b0 : rxClkCore; // RULE2
        s_d.rxDv = quiet ? 1'b0 : rxDvCore; // RULE2
        s_d.rxEr = quiet ? 1'b0 : rxErCore; // RULE2
        s_d.rxd = quiet ? 4'h0 : rxdCore; // RULE2
        s_d.crs = quiet ? 1'b0 : crsCore; // RULE2
        s_d.col = quiet ? 1'b0 : (colCore | (colTest & txEnSync)); // RULE10
        s_d.txEn = quiet ? 1'b0 : txEnSync; // RULE3
        s_d.txEr = quiet ? 1'b0 : txErSync; // RULE3
        s_d.txd = quiet ? 4'h0 : txdSync; // RULE3
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign txClkPin = s_q.txClk;
    assign rxClkPin = s_q.rxClk;
    assign rxDvPin = s_q.rxDv;
    assign rxErPin = s_q.rxEr;
    assign rxdPin = s_q.rxd;
    assign colPin = s_q.col;
    assign crsPin = s_q.crs;
    assign miiOe = s_q.oe;
    assign txEnCore = s_q.txEn;
    assign txErCore = s_q.txEr;
    assign txdCore = s_q.txd;

endmodule : pbc_mii_gate

// >>> verilog/pbc_regs.sv
// Basic control and status registers with their serial management slave.
module pbc_regs (
    input wire logic ref_clk,
    input wire logic rst,
    // Serial management pins
    input wire logic mdcPin,
    input wire logic mdioInPin,
    output logic mdioOutPin,
    output logic mdioOePin,
    input wire logic [4:0] phyAddrPin,
    // MAC-side MII transmit pins
    input wire logic txEnPin,
    input wire logic txErPin,
    input wire logic [3:0] txdPin,
    // MII outputs from the PHY core
    input wire logic txClkCore,
    input wire logic rxClkCore,
    input wire logic rxDvCore,
    input wire logic rxErCore,
    input wire logic [3:0] rxdCore,
    input wire logic colCore,
    input wire logic crsCore,
    // MAC-side MII output pins, one shared enable
    output logic txClkPin,
    output logic rxClkPin,
    output logic rxDvPin,
    output logic rxErPin,
    output logic [3:0] rxdPin,
    output logic colPin,
    output logic crsPin,
    output logic miiOe,
    // Transmit path into the PHY core
    output logic txEnCore,
    output logic txErCore,
    output logic [3:0] txdCore,
    // Negotiation engine and link monitor
    input wire logic anStarted,
    input wire logic anComplete,
    input wire logic anDuplex,
    input wire logic anSpeed,
    input wire logic partnerRemoteFault,
    input wire logic linkValid,
    // Controls to the PHY core
    output logic powerDown,
    output logic anEnable,
    output logic anRestartReq,
    output logic forcedSpeed,
    output logic forcedDuplex
);

    typedef struct packed {
        pbc_pkg::pbc_mgmt_state_t state;
        logic [5:0] preCnt;
        logic [3:0] bitCnt;
        logic [1:0] opcode;
        logic [9:0] addrShift;
        logic [15:0] shift;
        logic isRead;
        logic selected;
        logic mdcPrev;
        logic mdioOut;
        logic mdioOe;
        logic speedSel;
        logic anEn;
        logic powerDown;
        logic isolate;
        logic restart;
        logic duplexSel;
        logic colTest;
        logic linkLatch;
        logic remoteFaultFlag;
        logic restartPulse;
    } pbc_regs_state_t;

    localparam pbc_regs_state_t STATE_RESET = '{
        state: pbc_pkg::MG_PREAMBLE,
        preCnt: 6'h00,
        bitCnt: 4'h0,
        opcode: 2'h0,
        addrShift: 10'h000,
        shift: 16'h0000,
        isRead: 1'b0,
        selected: 1'b0,
        mdcPrev: 1'b0,
        mdioOut: 1'b0,
        mdioOe: 1'b0,
        speedSel: pbc_pkg::RST_SPEED,
        anEn: pbc_pkg::RST_AN_ENABLE,
        powerDown: pbc_pkg::RST_POWER_DOWN,
        isolate: pbc_pkg::RST_ISOLATE,
        restart: pbc_pkg::RST_RESTART,
        duplexSel: pbc_pkg::RST_DUPLEX,
        colTest: pbc_pkg::RST_COL_TEST,
        linkLatch: pbc_pkg::RST_LINK,
        remoteFaultFlag: pbc_pkg::RST_REMOTE_FAULT,
        restartPulse: 1'b0
    };

    pbc_regs_state_t s_d;
    pbc_regs_state_t s_q;

    logic [12:0] syncVec;
    logic mdcSync;
    logic mdioSync;
    logic txEnSync;
    logic txErSync;
    logic [3:0] txdSync;
    logic [4:0] phyAddrSync;
    logic mdcRise;
    logic statusRead;
    logic [9:0] addrNext;
    logic [15:0] wrData;

    // ==========================================================
    // Pin synchronisers
    pbc_sync #(
        .WIDTH(13)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .asyncIn({mdcPin, mdioInPin, txEnPin, txErPin, txdPin, phyAddrPin}),
        .syncOut(syncVec)
    );

    assign mdcSync = syncVec[12];
    assign mdioSync = syncVec[11];
    assign txEnSync = syncVec[10];
    assign txErSync = syncVec[9];
    assign txdSync = syncVec[8:5];
    assign phyAddrSync = syncVec[4:0];

    // ==========================================================
    // Register read view
    function automatic logic [15:0] readValue(
        input logic [4:0] regAddr,
        input pbc_regs_state_t st,
        input logic negDone,
        input logic negDuplex,
        input logic negSpeed
    );
        logic [15:0] v;
        v = 16'h0000; // RULE11
        if (regAddr == pbc_pkg::REG_CONTROL) begin
            v[pbc_pkg::CTL_SPEED] = st.anEn ? negSpeed : st.speedSel; // RULE19
            v[pbc_pkg::CTL_AN_ENABLE] = st.anEn;
            v[pbc_pkg::CTL_POWER_DOWN] = st.powerDown;
            v[pbc_pkg::CTL_ISOLATE] = st.isolate;
            v[pbc_pkg::CTL_RESTART] = st.restart; // RULE6
            v[pbc_pkg::CTL_DUPLEX] = st.anEn ? negDuplex : st.duplexSel; // RULE9
            v[pbc_pkg::CTL_COL_TEST] = st.colTest;
        end else if (regAddr == pbc_pkg::REG_STATUS) begin
            v = pbc_pkg::STS_FIXED; // RULE12 RULE13 RULE16
            v[pbc_pkg::STS_AN_COMPLETE] = negDone; // RULE14
            v[pbc_pkg::STS_REMOTE_FAULT] = st.remoteFaultFlag; // RULE15
            v[pbc_pkg::STS_LINK] = st.linkLatch; // RULE17
        end
        return v;
    endfunction : readValue

    // ==========================================================
    // Management slave and register update
    always_comb begin
        s_d = s_q;
        s_d.mdcPrev = mdcSync;
        s_d.restartPulse = 1'b0;
        mdcRise = mdcSync & ~s_q.mdcPrev;
        statusRead = 1'b0;
        addrNext = {s_q.addrShift[8:0], mdioSync};
        wrData = {s_q.shift[14:0], mdioSync};

        // Slave runs regardless of isolate and power-down
        if (mdcRise) begin // RULE1 RULE5
            unique case (s_q.state)
                pbc_pkg::MG_PREAMBLE: begin
                    if (mdioSync) begin
                        if (s_q.preCnt != pbc_pkg::PREAMBLE_MIN) begin
                            s_d.preCnt = s_q.preCnt + 6'h01;
                        end
                    end else begin
                        // Short preamble is refused
                        if (s_q.preCnt == pbc_pkg::PREAMBLE_MIN) begin // RULE13 RULE20
                            s_d.state = pbc_pkg::MG_START;
                        end
                        s_d.preCnt = 6'h00;
                    end
                end
                pbc_pkg::MG_START: begin
                    s_d.bitCnt = 4'h0;
                    s_d.state = mdioSync ? pbc_pkg::MG_OPCODE : pbc_pkg::MG_PREAMBLE;
                end
                pbc_pkg::MG_OPCODE: begin
                    s_d.opcode = {s_q.opcode[0], mdioSync};
                    s_d.bitCnt = s_q.bitCnt + 4'h1;
                    if (s_q.bitCnt == pbc_pkg::OPC_LAST) begin
                        s_d.bitCnt = 4'h0;
                        s_d.isRead = ({s_q.opcode[0], mdioSync} == pbc_pkg::OP_READ);
                        if (({s_q.opcode[0], mdioSync} == pbc_pkg::OP_READ)
                                || ({s_q.opcode[0], mdioSync} == pbc_pkg::OP_WRITE)) begin
                            s_d.state = pbc_pkg::MG_ADDRESS;
                        end else begin
                            s_d.state = pbc_pkg::MG_PREAMBLE;
                        end
                    end
                end
                pbc_pkg::MG_ADDRESS: begin
                    s_d.addrShift = addrNext;
                    s_d.bitCnt = s_q.bitCnt + 4'h1;
                    if (s_q.bitCnt == pbc_pkg::ADDR_LAST) begin
                        s_d.bitCnt = 4'h0;
                        s_d.selected = (addrNext[9:5] == phyAddrSync);
                        s_d.state = pbc_pkg::MG_TURN;
                        if (s_q.isRead && (addrNext[9:5] == phyAddrSync)) begin
                            s_d.shift = readValue(addrNext[4:0], s_q, anComplete,
                                anDuplex, anSpeed);
                            statusRead = (addrNext[4:0] == pbc_pkg::REG_STATUS); // RULE21
                        end
                    end
                end
                pbc_pkg::MG_TURN: begin
                    if (s_q.bitCnt == 4'h0) begin
                        s_d.bitCnt = 4'h1;
                        if (s_q.isRead && s_q.selected) begin
                            s_d.mdioOe = 1'b1;
                            s_d.mdioOut = 1'b0;
                        end
                    end else begin
                        s_d.bitCnt = 4'h0;
                        s_d.state = pbc_pkg::MG_DATA;
                        if (s_q.isRead && s_q.selected) begin
                            s_d.mdioOut = s_q.shift[15];
                            s_d.shift = {s_q.shift[14:0], 1'b0};
                        end
                    end
                end
                pbc_pkg::MG_DATA: begin
                    s_d.bitCnt = s_q.bitCnt + 4'h1;
                    if (s_q.isRead) begin
                        s_d.mdioOut = s_q.shift[15];
                        s_d.shift = {s_q.shift[14:0], 1'b0};
                    end else begin
                        s_d.shift = wrData;
                    end
                    if (s_q.bitCnt == pbc_pkg::DATA_LAST) begin
                        // Each frame needs a fresh preamble
                        s_d.state = pbc_pkg::MG_PREAMBLE;
                        s_d.bitCnt = 4'h0;
                        s_d.mdioOe = 1'b0;
                        s_d.mdioOut = 1'b0;
                        if (!s_q.isRead && s_q.selected
                                && (s_q.addrShift[4:0] == pbc_pkg::REG_CONTROL)) begin
                            s_d.speedSel = wrData[pbc_pkg::CTL_SPEED];
                            s_d.anEn = wrData[pbc_pkg::CTL_AN_ENABLE]; // RULE19
                            s_d.powerDown = wrData[pbc_pkg::CTL_POWER_DOWN];
                            s_d.isolate = wrData[pbc_pkg::CTL_ISOLATE];
                            s_d.duplexSel = wrData[pbc_pkg::CTL_DUPLEX]; // RULE9
                            s_d.colTest = wrData[pbc_pkg::CTL_COL_TEST]; // RULE10
                            // Writing zero only drops the readback, engine untouched
                            s_d.restart = 1'b0; // RULE8
                            if (wrData[pbc_pkg::CTL_RESTART]
                                    && wrData[pbc_pkg::CTL_AN_ENABLE]) begin // RULE7
                                s_d.restart = 1'b1; // RULE6
                                s_d.restartPulse = 1'b1; // RULE6
                            end
                        end
                    end
                end
                default: begin
                    s_d.state = pbc_pkg::MG_PREAMBLE;
                    s_d.mdioOe = 1'b0;
                end
            endcase
        end

        // Restart bit drops once the engine has begun
        if (anStarted && !s_d.restartPulse) begin
            s_d.restart = 1'b0; // RULE6
        end

        // A failure in the read cycle still clears the latch
        s_d.linkLatch = statusRead ? linkValid : (s_q.linkLatch & linkValid); // RULE17 RULE18
        s_d.remoteFaultFlag = partnerRemoteFault
            | (s_q.remoteFaultFlag & ~statusRead); // RULE15 RULE21
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_q <= STATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // MII gating
    pbc_mii_gate u_gate (
        .ref_clk(ref_clk),
        .rst(rst),
        .isolate(s_q.isolate),
        .powerDown(s_q.powerDown),
        .colTest(s_q.colTest),
        .txEnSync(txEnSync),
        .txErSync(txErSync),
        .txdSync(txdSync),
        .txClkCore(txClkCore),
        .rxClkCore(rxClkCore),
        .rxDvCore(rxDvCore),
        .rxErCore(rxErCore),
        .rxdCore(rxdCore),
        .colCore(colCore),
        .crsCore(crsCore),
        .txClkPin(txClkPin),
        .rxClkPin(rxClkPin),
        .rxDvPin(rxDvPin),
        .rxErPin(rxErPin),
        .rxdPin(rxdPin),
        .colPin(colPin),
        .crsPin(crsPin),
        .miiOe(miiOe),
        .txEnCore(txEnCore),
        .txErCore(txErCore),
        .txdCore(txdCore)
    );

    // ==========================================================
    // Outputs
    assign mdioOutPin = s_q.mdioOut;
    assign mdioOePin = s_q.mdioOe;
    assign powerDown = s_q.powerDown; // RULE2
    assign anEnable = s_q.anEn;
    assign anRestartReq = s_q.restartPulse; // RULE6
    assign forcedSpeed = s_q.speedSel;
    assign forcedDuplex = s_q.duplexSel; // RULE9

endmodule : pbc_regs

// >>> tb/pbc_regs_asserts.sv
// Checker for the basic control and status registers
module pbc_regs_asserts (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic mdioOutPin,
    input wire logic mdioOePin,
    input wire logic rxDvPin,
    input wire logic [3:0] rxdPin,
    input wire logic colPin,
    input wire logic crsPin,
    input wire logic miiOe,
    input wire logic [3:0] rxdCore,
    input wire logic txEnCore,
    input wire logic [3:0] txdCore,
    input wire logic anEnable,
    input wire logic anRestartReq,
    input wire logic powerDown,
    input wire logic forcedSpeed,
    input wire logic forcedDuplex
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ======
    // Sequences
    sequence s_quiet;
        !rxDvPin && rxdPin == 4'h0 && !colPin && !crsPin;
    endsequence
    sequence s_turn;
        $rose(mdioOePin) && !mdioOutPin;
    endsequence
    // ======
    // Properties
    chk_pd_quiet: assert property (powerDown && $past(powerDown) |-> s_quiet)
        else $error("MII active in power-down");
    chk_pd_tx: assert property (powerDown && $past(powerDown) |-> !txEnCore && txdCore == 4'h0)
        else $error("TX active in power-down");
    chk_iso_out: assert property (!miiOe |-> s_quiet)
        else $error("MII active while released");
    chk_iso_tx: assert property (!miiOe && !$past(miiOe) |-> !txEnCore)
        else $error("TX enable passed isolated");
    chk_rx_follow: assert property (miiOe && !powerDown && !$past(powerDown)
        |-> rxdPin == $past(rxdCore))
        else $error("RX data not passed");
    chk_rst_ctl: assert property ($past(rst) |-> anEnable && forcedSpeed && forcedDuplex
        && !powerDown)
        else $error("bad controls after reset");
    chk_restart_one: assert property (anRestartReq |=> !anRestartReq)
        else $error("restart pulse too long");
    chk_restart_en: assert property (anRestartReq |-> anEnable || $past(anEnable))
        else $error("restart with negotiation off");
    chk_mdio_turn: assert property ($rose(mdioOePin) |-> !mdioOutPin)
        else $error("turnaround bit not zero");
    chk_mdio_hold: assert property (s_turn |-> mdioOePin[*8])
        else $error("read drive dropped early");
endmodule : pbc_regs_asserts

bind pbc_regs pbc_regs_asserts i_pbc_regs_asserts (.*);

// >>> tb/pbc_mgmt_host.sv
// Management host model driving MDC/MDIO frames
module pbc_mgmt_host (
    input wire logic ref_clk,
    input wire logic mdioOutPin,
    input wire logic mdioOePin,
    output logic mdcPin,
    output logic mdioInPin
);
    timeunit 1ns;
    timeprecision 1ps;
    int half = 5;
    logic hostOe = 1'b0;
    logic hostDat = 1'b1;
    initial mdcPin = 1'b0;
    // Pull-up wins when nobody drives
    assign mdioInPin = mdioOePin ? mdioOutPin : (hostOe ? hostDat : 1'b1);
    // One bit per MDC period
    task automatic bit_cyc(input logic oe, input logic d, output logic s);
        @(negedge ref_clk);
        mdcPin = 1'b0;
        hostOe = oe;
        hostDat = d;
        repeat (half) @(negedge ref_clk);
        s = mdioInPin;
        mdcPin = 1'b1;
        repeat (half - 1) @(negedge ref_clk);
    endtask : bit_cyc
    task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
            input logic [15:0] wd, input int pre, output logic [15:0] rd);
        logic [63:0] f;
        logic s;
        f = {32'hFFFFFFFF, 2'b01, op, pa, ra, 2'b10, wd};
        for (int i = 32 - pre; i < 64; i++) begin
            bit_cyc(i < 46 || op == pbc_pkg::OP_WRITE, f[63 - i], s);
            rd = {rd[14:0], s};
        end
        // Closing zero so stray idle ones never count as preamble
        bit_cyc(1'b1, 1'b0, s);
    endtask : frame
endmodule : pbc_mgmt_host

// >>> tb/tb.sv
// Testbench for the basic control and status registers
module automatic tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic mdcPin, mdioInPin, mdioOutPin, mdioOePin;
    logic txEnPin = 1'b0;
    logic [3:0] core = 4'h0;
    logic [6:0] cv = 7'h00;
    logic anStarted = 1'b0, anComplete = 1'b0, anDuplex = 1'b1, anSpeed = 1'b1;
    logic partnerRemoteFault = 1'b0, linkValid = 1'b0;
    logic txClkPin, rxClkPin, rxDvPin, rxErPin, colPin, crsPin, miiOe, txEnCore, txErCore;
    logic [3:0] rxdPin, txdCore;
    logic powerDown, anEnable, anRestartReq, forcedSpeed, forcedDuplex;
    int fail_count = 0, tests_run = 0, pulses = 0;
    localparam logic [4:0] CTL = pbc_pkg::REG_CONTROL, STS = pbc_pkg::REG_STATUS;
    pbc_mgmt_host i_pbc_mgmt_host (.ref_clk, .mdioOutPin, .mdioOePin, .mdcPin, .mdioInPin);
    pbc_regs i_pbc_regs (.ref_clk, .rst, .mdcPin, .mdioInPin, .mdioOutPin, .mdioOePin,
        .phyAddrPin(5'h01), .txEnPin, .txErPin(txEnPin), .txdPin(core), .txClkCore(cv[0]),
        .rxClkCore(cv[1]), .rxDvCore(cv[2]), .rxErCore(cv[3]), .rxdCore(core), .colCore(cv[4]),
        .crsCore(cv[5]), .txClkPin, .rxClkPin, .rxDvPin, .rxErPin, .rxdPin, .colPin, .crsPin,
        .miiOe, .txEnCore, .txErCore, .txdCore, .anStarted, .anComplete, .anDuplex, .anSpeed,
        .partnerRemoteFault, .linkValid, .powerDown, .anEnable, .anRestartReq, .forcedSpeed,
        .forcedDuplex);
    initial forever #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (anRestartReq === 1'b1) pulses++;
    // ======
    // Helpers
    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task wr(input logic [4:0] ra, input logic [15:0] d, input int pre = 32);
        logic [15:0] r;
        i_pbc_mgmt_host.frame(pbc_pkg::OP_WRITE, 5'h01, ra, d, pre, r);
    endtask : wr
    task rd(input logic [4:0] ra, input logic [15:0] exp, input string what);
        logic [15:0] r;
        i_pbc_mgmt_host.frame(pbc_pkg::OP_READ, 5'h01, ra, 16'h0000, 32, r);
        chk(what, exp, r);
    endtask : rd
    task print_verdict();
        if (fail_count == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict
    // ======
    // Scenarios
    task t_reset();
        rd(CTL, 16'h3100, "control reset");
        rd(STS, 16'h7808, "status reset");
        rd(5'h02, 16'h0000, "unmapped");
    endtask : t_reset
    task t_latch();
        @(negedge ref_clk);
        linkValid = 1'b1;
        rd(STS, 16'h7808, "link latched low");
        rd(STS, 16'h780C, "link up");
        @(negedge ref_clk);
        linkValid = 1'b0;
        partnerRemoteFault = 1'b1;
        @(negedge ref_clk);
        linkValid = 1'b1;
        partnerRemoteFault = 1'b0;
        anComplete = 1'b1;
        wr(STS, 16'h0000);
        rd(STS, 16'h7838, "fault and link drop");
        rd(STS, 16'h782C, "latches cleared");
    endtask : t_latch
    task t_restart();
        wr(CTL, 16'h3300);
        rd(CTL, 16'h3300, "restart pending");
        wr(CTL, 16'h3100);
        chk("restart pulses", 16'h0001, pulses[15:0]);
        wr(CTL, 16'h3300);
        @(negedge ref_clk);
        anStarted = 1'b1;
        @(negedge ref_clk);
        anStarted = 1'b0;
        rd(CTL, 16'h3100, "restart self clear");
        wr(CTL, 16'h0100);
        wr(CTL, 16'h0300);
        rd(CTL, 16'h0100, "restart ignored");
        chk("restart pulses", 16'h0002, pulses[15:0]);
    endtask : t_restart
    task t_duplex();
        wr(CTL, 16'h007F);
        rd(CTL, 16'h0000, "forced half");
        chk("forced pins", 16'h0000, {14'h0000, forcedSpeed, forcedDuplex});
        @(negedge ref_clk);
        anDuplex = 1'b0;
        wr(CTL, 16'h1100);
        rd(CTL, 16'h3000, "negotiated duplex");
        anDuplex = 1'b1;
    endtask : t_duplex
    task t_mii();
        @(negedge ref_clk);
        core = 4'hA;
        cv = 7'h2F;
        txEnPin = 1'b1;
        wr(CTL, 16'h3500);
        chk("isolated", 16'h0000, {8'h00, miiOe, txEnCore, rxDvPin, colPin, rxdPin});
        rd(STS, 16'h782C, "status isolated");
        wr(CTL, 16'h3900);
        chk("powered down", 16'h0080, {8'h00, miiOe, txEnCore, rxDvPin, colPin, rxdPin});
        rd(CTL, 16'h3900, "control powered down");
        wr(CTL, 16'h3180);
        chk("col test", 16'h00FA, {8'h00, miiOe, txEnCore, rxDvPin, colPin, rxdPin});
        @(negedge ref_clk);
        txEnPin = 1'b0;
        repeat (4) @(negedge ref_clk);
        chk("col test idle", 16'h0000, {15'h0000, colPin});
        wr(CTL, 16'h3100);
    endtask : t_mii
    task t_refuse();
        logic [15:0] r;
        wr(CTL, 16'h3500, 31);
        i_pbc_mgmt_host.frame(pbc_pkg::OP_WRITE, 5'h07, CTL, 16'h3500, 32, r);
        i_pbc_mgmt_host.frame(pbc_pkg::OP_READ, 5'h07, CTL, 16'h0000, 32, r);
        chk("foreign address silent", 16'hFFFF, r);
        i_pbc_mgmt_host.half = 9;
        rd(CTL, 16'h3100, "refused writes");
    endtask : t_refuse
    initial begin
        #400us;
        fail_count++;
        print_verdict();
    end
    initial begin
        repeat (20) @(negedge ref_clk);
        rst = 1'b0;
        @(negedge ref_clk);
        t_reset();
        t_latch();
        t_restart();
        t_duplex();
        t_mii();
        t_refuse();
        print_verdict();
    end
endmodule : tb
